/* pkg/spfe_pkg.sv */
// Purpose: Shared constants and types of the serial port frame engine.
// Assumes: One clock; registers reached over a plain strobe port.
// Notes: Counts are in clock cycles or in divide-by-16 counter states.
`default_nettype none
package spfe_pkg;
  // Register offsets (register index on the plain port)
  localparam logic [1:0] SPFE_OFS_CTRL = 2'h0;
  localparam logic [1:0] SPFE_OFS_BUF = 2'h1;
  localparam logic [1:0] SPFE_OFS_AUX = 2'h2;
  // Control register field positions
  localparam int SPFE_B_MODE_HI = 7;
  localparam int SPFE_B_MODE_LO = 6;
  localparam int SPFE_B_MPEN = 5;
  localparam int SPFE_B_REN = 4;
  localparam int SPFE_B_TX9 = 3;
  localparam int SPFE_B_RX9 = 2;
  localparam int SPFE_B_TXDONE = 1;
  localparam int SPFE_B_RXDONE = 0;
  // Auxiliary register field positions
  localparam int SPFE_B_DBL = 0;
  localparam int SPFE_B_SIX = 1;
  // Reset values
  localparam logic [7:0] SPFE_RST_CTRL = 8'h00;
  localparam logic [7:0] SPFE_RST_BUF = 8'h00;
  localparam logic [1:0] SPFE_RST_AUX = 2'h0;
  // Receive shift register preload values
  localparam logic [8:0] SPFE_RX_PRELOAD = 9'h1FF;
  localparam logic [7:0] SPFE_M0_PRELOAD = 8'h7F;
  // Divide-by-16 counter states
  localparam logic [3:0] SPFE_DIV_LAST = 4'hF;
  localparam logic [3:0] SPFE_SAMP_A = 4'h7;
  localparam logic [3:0] SPFE_SAMP_B = 4'h8;
  localparam logic [3:0] SPFE_SAMP_C = 4'h9;
  // Machine cycle length in oscillator clocks
  localparam logic [3:0] SPFE_MC_12 = 4'hC;
  localparam logic [3:0] SPFE_MC_6 = 4'h6;
  // Mode two tick divider reloads, one less than the spacing in clocks (16x bit rate)
  localparam logic [1:0] SPFE_M2_DIV_SLOW = 2'h3;
  localparam logic [1:0] SPFE_M2_DIV_FAST = 2'h1;
  // Transmit end pattern: marker beside the last bit
  localparam logic [7:0] SPFE_TX_END = 8'h01;

  // Operating modes
  typedef enum logic [1:0] {
    SPFE_MODE_SHIFT = 2'h0,
    SPFE_MODE_ONE = 2'h1,
    SPFE_MODE_TWO = 2'h2,
    SPFE_MODE_THREE = 2'h3
  } spfe_mode_e;

  // One register request from software
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spfe_req_s;
endpackage
`default_nettype wire

/* src/spfe_frame_engine.sv */
// Purpose: Transmit and receive framing of a microcontroller serial port.
// Assumes: clock is the oscillator; baud_tick_16x comes from a timer.
// Notes: Shift-register mode covers reception only.
//
// Contract
// - Mode zero shifts in fifth-state pin sample.
// - Mode zero ends on marker, sets receive-done.
// - Mode one frame: start, eight data, stop.
// - Mode one stop bit stored as ninth bit.
// - Buffer write arms transmit at next rollover.
// - Start bit, then data, then first shift.
// - Mode one marker ends transmit, sets done.
// - Falling edge resets counter, preloads shift register.
// - Majority of samples at states seven-nine.
// - Non-zero start bit restarts the hunt.
// - Nine-bit register, start at end finishes.
// - Mode one acceptance needs flag clear, stop if multiprocessor on.
// - Mode one returns to hunting after frame.
// - Modes two, three carry programmable ninth bit.
// - Mode two rate from oscillator, selectable.
// - Modes one, three use timer rate.
// - Ninth bit loaded, then stop, then zeros.
// - Modes two, three end at eleventh rollover.
// - Ninth-bit acceptance needs flag clear, bit one if multiprocessor on.
// - Hunting resumes one bit time after end.
// - Mode zero receives when enabled, flag clear.
// - Mode zero rate is one per machine cycle.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module spfe_frame_engine
  import spfe_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire spfe_req_s req,
  output logic [7:0] rdata,
  // Timer overflow tick at sixteen times the bit rate
  input wire logic baud_tick_16x,
  // Serial pins
  input wire logic port_three_bit_zero,
  output logic txd
);

  // Transmit states
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_WAIT = 4'b0010,
    TX_START = 4'b0100,
    TX_DATA = 4'b1000
  } spfe_tx_e;

  // Receive states
  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_BITS = 4'b0010,
    RX_TAIL = 4'b0100,
    RX_SHIFT0 = 4'b1000
  } spfe_rx_e;

  // Two-of-three vote for noise rejection
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Software-visible state
  logic [7:0] ctrl_r; // Control register
  logic [7:0] serial_buffer; // Received byte
  logic [1:0] aux_r; // Rate selects
  logic [7:0] rdata_r; // Read data, one cycle after strobe
  // Pin synchroniser
  logic rx_meta_r;
  logic rx_s_r;
  // Timing
  logic [3:0] mc_cnt_r; // Position inside a machine cycle
  logic [1:0] m2_cnt_r; // Mode two tick divider
  logic [3:0] div16_r; // Bit-time counter
  // Transmit
  spfe_tx_e tx_st_r;
  logic [8:0] tx_sr_r; // Transmit shift register
  logic tx_first_r; // First shift not yet made
  logic txd_r;
  // Receive
  spfe_rx_e rx_st_r;
  logic [8:0] rx_sr_r; // Receive shift register
  logic [7:0] m0_sr_r; // Shift-register mode receive register
  logic rx_prev_r; // Previous tick sample
  logic samp_a_r, samp_b_r; // Votes at counter states seven and eight
  logic m0_samp_r; // Shift-mode pin level, held until the shift

  // Decoded fields and strobes, grouped by concern
  spfe_mode_e mode;
  logic [3:0] mc_last; // Last count of a machine cycle
  // Control fields
  logic multiproc_enable, ren, tx_ninth_bit, rx_done_flag, six_clock;
  // Write decodes and machine cycle phases
  logic wr_ctrl, wr_buf, state_five_phase_two, s6p2;
  // Bit timing and receive decisions
  logic tick, rollover, bit_val, at_bit, rx_edge;
  logic rx_final, rx_accept, m0_final;
  // Transmit progress and flag sets
  logic tx_shift, tx_end, tx_set_done, rx_set_done;

  assign mode = spfe_mode_e'(ctrl_r[SPFE_B_MODE_HI:SPFE_B_MODE_LO]);
  assign multiproc_enable = ctrl_r[SPFE_B_MPEN];
  assign ren = ctrl_r[SPFE_B_REN];
  assign tx_ninth_bit = ctrl_r[SPFE_B_TX9];
  assign rx_done_flag = ctrl_r[SPFE_B_RXDONE];
  assign six_clock = aux_r[SPFE_B_SIX];
  assign wr_ctrl = req.wr && (req.addr == SPFE_OFS_CTRL);
  assign wr_buf = req.wr && (req.addr == SPFE_OFS_BUF);

  // Machine cycle phases: fifth and sixth state in either clock option
  assign mc_last = six_clock ? (SPFE_MC_6 - 4'h1) : (SPFE_MC_12 - 4'h1);
  assign state_five_phase_two = six_clock ? (mc_cnt_r == 4'h4) :
                                (mc_cnt_r == 4'h9);
  assign s6p2 = (mc_cnt_r == mc_last);

  // Tick source: oscillator in mode two, timer otherwise
  assign tick = (mode == SPFE_MODE_TWO) ? (m2_cnt_r == 2'h0) :
                baud_tick_16x;
  assign rollover = tick && (div16_r == SPFE_DIV_LAST);

  // Bit decision at the third sample point
  assign at_bit = tick && (div16_r == SPFE_SAMP_C);
  assign bit_val = maj3(samp_a_r, samp_b_r, rx_s_r);
  assign rx_edge = (rx_st_r == RX_HUNT) && (mode != SPFE_MODE_SHIFT) &&
                   ren && tick && rx_prev_r && !rx_s_r;
  // Start bit reached the far end: this shift is the last
  assign rx_final = (rx_st_r == RX_BITS) && at_bit && !rx_sr_r[0];
  assign rx_accept = rx_final && !rx_done_flag &&
                     (!multiproc_enable || bit_val);
  assign m0_final = (rx_st_r == RX_SHIFT0) && s6p2 && !m0_sr_r[0];

  // Transmit shift on rollovers while data drives the pin
  assign tx_shift = (tx_st_r == TX_DATA) && rollover;
  assign tx_end = !tx_first_r && (tx_sr_r[8:1] == SPFE_TX_END);
  assign tx_set_done = tx_shift && tx_end;
  assign rx_set_done = rx_accept || m0_final;

  // Two-flop synchroniser on the receive pin
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_meta_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_meta_r <= port_three_bit_zero;
      rx_s_r <= rx_meta_r;
    end
  end

  // Machine cycle position counter
  always_ff @(posedge clock) begin
    if (srst) begin
      mc_cnt_r <= 4'h0;
    end else if (mc_cnt_r >= mc_last) begin
      mc_cnt_r <= 4'h0;
    end else begin
      mc_cnt_r <= mc_cnt_r + 4'h1;
    end
  end

  // Mode two divider: tick every 4 or 2 clocks, halved in six-clock mode
  always_ff @(posedge clock) begin
    if (srst) begin
      m2_cnt_r <= 2'h0;
    end else if (m2_cnt_r == 2'h0) begin
      // Doubling bit halves the spacing; six-clock halves it again
      case ({aux_r[SPFE_B_DBL], six_clock})
        2'b00: m2_cnt_r <= SPFE_M2_DIV_SLOW;
        2'b11: m2_cnt_r <= 2'h0;
        default: m2_cnt_r <= SPFE_M2_DIV_FAST;
      endcase
    end else begin
      m2_cnt_r <= m2_cnt_r - 2'h1;
    end
  end

  // Divide-by-16 counter, shared by both directions
  always_ff @(posedge clock) begin
    if (srst) begin
      div16_r <= 4'h0;
    end else if (rx_edge) begin
      div16_r <= 4'h0;
    end else if (tick) begin
      div16_r <= div16_r + 4'h1;
    end
  end

  // Pin samples at counter states seven and eight
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_prev_r <= 1'b1;
      samp_a_r <= 1'b1;
      samp_b_r <= 1'b1;
    end else if (tick) begin
      rx_prev_r <= rx_s_r;
      if (div16_r == SPFE_SAMP_A) begin
        samp_a_r <= rx_s_r;
      end
      if (div16_r == SPFE_SAMP_B) begin
        samp_b_r <= rx_s_r;
      end
    end
  end

  // Shift-mode pin sample, taken a state before the shift uses it
  always_ff @(posedge clock) begin
    if (srst) begin
      m0_samp_r <= 1'b1;
    end else if (state_five_phase_two) begin
      m0_samp_r <= rx_s_r;
    end
  end

  // Receive sequencer for all modes
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_st_r <= RX_HUNT;
      rx_sr_r <= SPFE_RX_PRELOAD;
      m0_sr_r <= SPFE_M0_PRELOAD;
    end else begin
      case (rx_st_r)
        RX_HUNT: begin
          if (mode == SPFE_MODE_SHIFT) begin
            // Shift mode waits for enable with the flag clear
            if (ren && !rx_done_flag && s6p2) begin
              m0_sr_r <= SPFE_M0_PRELOAD;
              rx_st_r <= RX_SHIFT0;
            end
          end else if (rx_edge) begin
            rx_sr_r <= SPFE_RX_PRELOAD;
            rx_st_r <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (at_bit) begin
            if (rx_sr_r == SPFE_RX_PRELOAD && bit_val) begin
              rx_st_r <= RX_HUNT;
            end else begin
              rx_sr_r <= {bit_val, rx_sr_r[8:1]};
              if (rx_final) begin
                // Mode one is back at once; ninth-bit modes wait
                rx_st_r <= (mode == SPFE_MODE_ONE) ? RX_HUNT :
                           RX_TAIL;
              end
            end
          end
        end
        RX_TAIL: begin
          // Stop bit passes before the hunt resumes
          if (at_bit) begin
            rx_st_r <= RX_HUNT;
          end
        end
        RX_SHIFT0: begin
          // One bit per machine cycle, latched fifth-state sample
          if (s6p2) begin
            m0_sr_r <= {m0_samp_r, m0_sr_r[7:1]};
            if (!m0_sr_r[0]) begin
              rx_st_r <= RX_HUNT;
            end
          end
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  // Receive buffer: loaded only by an accepted frame or a finished shift-mode byte
  always_ff @(posedge clock) begin
    if (srst) begin
      serial_buffer <= SPFE_RST_BUF;
    end else if (rx_accept) begin
      serial_buffer <= rx_sr_r[8:1];
    end else if (m0_final) begin
      serial_buffer <= {m0_samp_r, m0_sr_r[7:1]};
    end
  end

  // Control register: hardware set wins over a software clear
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= SPFE_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= req.wdata;
      end
      if (rx_accept) begin
        ctrl_r[SPFE_B_RX9] <= bit_val;
      end
      if (rx_set_done) begin
        ctrl_r[SPFE_B_RXDONE] <= 1'b1;
      end
      if (tx_set_done) begin
        ctrl_r[SPFE_B_TXDONE] <= 1'b1;
      end
    end
  end

  // Auxiliary rate register
  always_ff @(posedge clock) begin
    if (srst) begin
      aux_r <= SPFE_RST_AUX;
    end else if (req.wr && (req.addr == SPFE_OFS_AUX)) begin
      aux_r <= req.wdata[1:0];
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        SPFE_OFS_CTRL: rdata_r <= ctrl_r;
        SPFE_OFS_BUF: rdata_r <= serial_buffer;
        SPFE_OFS_AUX: rdata_r <= {6'h00, aux_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;

  // Transmit sequencer, bit times tied to the counter not the write
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_st_r <= TX_IDLE;
      tx_sr_r <= 9'h000;
      tx_first_r <= 1'b0;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          // Shift-mode transmit is not offered
          if (wr_buf && (mode != SPFE_MODE_SHIFT)) begin
            tx_sr_r <= {(mode == SPFE_MODE_ONE) ? 1'b1 : tx_ninth_bit,
                        req.wdata};
            tx_first_r <= 1'b1;
            tx_st_r <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (rollover) begin
            tx_st_r <= TX_START;
          end
        end
        TX_START: begin
          if (rollover) begin
            tx_st_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_shift) begin
            // Stop bit enters first in ninth-bit modes, then zeros
            tx_sr_r <= {tx_first_r && (mode != SPFE_MODE_ONE),
                        tx_sr_r[8:1]};
            tx_first_r <= 1'b0;
            if (tx_end) begin
              tx_st_r <= TX_IDLE;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Pin driver: shift clock in mode zero, frame bits otherwise
  always_ff @(posedge clock) begin
    if (srst) begin
      txd_r <= 1'b1;
    end else if (rx_st_r == RX_SHIFT0) begin
      // Low in S3 to S5, high in S6, S1, S2
      txd_r <= six_clock ? !(mc_cnt_r >= 4'h1 && mc_cnt_r < 4'h4) :
               !(mc_cnt_r >= 4'h3 && mc_cnt_r < 4'h9);
    end else begin
      case (tx_st_r)
        TX_START: txd_r <= 1'b0;
        TX_DATA: txd_r <= tx_sr_r[0];
        default: txd_r <= 1'b1;
      endcase
    end
  end
  assign txd = txd_r;

  // Checks
  a_tx_idle_high: assert property (@(posedge clock) disable iff (srst)
    (tx_st_r == TX_IDLE && rx_st_r != RX_SHIFT0) |=> txd)
    else $error("transmit pin not idle high");
  a_start_bit_low: assert property (@(posedge clock) disable iff (srst)
    (tx_st_r == TX_START) ##1 (tx_st_r == TX_START) |-> !txd)
    else $error("start bit not low");
  a_hunt_preload: assert property (@(posedge clock) disable iff (srst)
    rx_edge |=> (div16_r == 4'h0 && rx_sr_r == 9'h1FF))
    else $error("edge did not reset counter and preload");
  a_false_start: assert property (@(posedge clock) disable iff (srst)
    (at_bit && rx_st_r == RX_BITS && rx_sr_r == 9'h1FF && bit_val)
    |=> rx_st_r == RX_HUNT)
    else $error("false start not rejected");
  a_reject_keeps: assert property (@(posedge clock) disable iff (srst)
    (rx_final && rx_done_flag) |=> $stable(serial_buffer))
    else $error("frame taken while flag set");
  a_accept_loads: assert property (@(posedge clock) disable iff (srst)
    rx_accept |=> (rx_done_flag &&
    serial_buffer == $past(rx_sr_r[8:1])))
    else $error("accepted frame not stored");
  a_mode1_rehunt: assert property (@(posedge clock) disable iff (srst)
    (rx_final && mode == SPFE_MODE_ONE) |=> rx_st_r == RX_HUNT)
    else $error("mode one did not resume hunting");
  a_tx_done_set: assert property (@(posedge clock) disable iff (srst)
    tx_set_done |=> (ctrl_r[SPFE_B_TXDONE] && tx_st_r == TX_IDLE))
    else $error("transmit end not flagged");
  a_tx_waits_roll: assert property (@(posedge clock) disable iff (srst)
    (tx_st_r == TX_WAIT && !rollover) |=> tx_st_r == TX_WAIT)
    else $error("transmit began off a rollover");
  a_m0_shift_in: assert property (@(posedge clock) disable iff (srst)
    (rx_st_r == RX_SHIFT0 && s6p2 && m0_sr_r[0])
    |=> m0_sr_r[7] == $past(m0_samp_r))
    else $error("mode zero bit not shifted in");
  a_m0_start_cond: assert property (@(posedge clock) disable iff (srst)
    (rx_st_r == RX_HUNT && mode == SPFE_MODE_SHIFT && rx_done_flag)
    |=> rx_st_r != RX_SHIFT0)
    else $error("mode zero started with flag set");

endmodule
`default_nettype wire

/* verification/spfe_remote_node.sv */
// Purpose: Remote serial node facing the frame engine's serial pins.
// Assumes: Fixed bit time in clocks per send; 32 clocks per bit on capture.
// Notes: Behavioural; the bench chooses every frame, including bad starts.
`timescale 1ns/100ps
`default_nettype none
module spfe_remote_node (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Serial lines
  input wire logic txd,
  output logic line,
  // Send request, bits LSB first, start bit included
  input wire logic go,
  input wire logic [3:0] go_len,
  input wire logic [10:0] go_bits,
  input wire logic [5:0] go_clks,
  output logic busy,
  // Shift-mode partner: byte sent on the engine's shift clock
  input wire logic m0_en,
  input wire logic [7:0] m0_byte,
  // Frame capture from the engine
  input wire logic [3:0] rx_len,
  output logic frame_valid,
  output logic [10:0] frame_bits
);
  logic [5:0] s_cnt; // Clocks into current sent bit
  logic [3:0] s_idx; // Index of the bit on the line
  logic [10:0] s_bits; // Frame being sent
  logic [5:0] r_cnt; // Clocks counted toward the next sample point
  logic [3:0] r_idx; // Index of next captured bit
  logic r_busy; // Capture in progress
  logic txd_q; // Last txd, for edge search
  logic [7:0] m0_sh; // Shift-mode bits still to send

  // Sender: a short one-bit frame makes a false start
  always @(posedge clock) begin
    if (srst) begin
      line <= 1'b1;
      busy <= 1'b0;
    end else if (m0_en) begin
      // Next bit goes out after each rising shift clock
      line <= m0_sh[0];
      if (!txd_q && txd) begin
        m0_sh <= {1'b1, m0_sh[7:1]};
      end
    end else if (!busy) begin
      // Idle line rests high, as its pull-up would hold it
      line <= 1'b1;
      m0_sh <= m0_byte;
      if (go) begin
        busy <= 1'b1;
        s_cnt <= '0;
        s_idx <= '0;
        s_bits <= go_bits;
        line <= go_bits[0];
      end
    end else if (s_cnt == go_clks - 6'd1) begin
      s_cnt <= '0;
      s_idx <= s_idx + 4'd1;
      // Released line goes back high, as a pulled-up idle line would
      if (s_idx == go_len - 4'd1) begin
        busy <= 1'b0;
        line <= 1'b1;
      end else begin
        line <= s_bits[s_idx + 4'd1];
      end
    end else begin
      s_cnt <= s_cnt + 6'd1;
    end
  end

  // Capture: sample mid-bit, start bit lands in bit 0
  always @(posedge clock) begin
    txd_q <= txd;
    frame_valid <= 1'b0;
    if (srst) begin
      r_busy <= 1'b0;
    end else if (!r_busy) begin
      if (txd_q && !txd && !m0_en) begin
        r_busy <= 1'b1;
        r_cnt <= '0;
        r_idx <= '0;
        frame_bits <= '0;
      end
    end else if (r_cnt == ((r_idx == 4'd0) ? 6'd15 : 6'd31)) begin
      r_cnt <= '0;
      r_idx <= r_idx + 4'd1;
      frame_bits[r_idx] <= txd;
      if (r_idx == rx_len - 4'd1) begin
        r_busy <= 1'b0;
        frame_valid <= 1'b1;
      end
    end else begin
      r_cnt <= r_cnt + 6'd1;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_serial_port_frame_engine.sv */
// Purpose: Self-checking bench of the serial port frame engine.
// Assumes: Tick every second clock, so a bit lasts 32 clocks.
// Notes: Mode 2 runs with rate doubling to match that bit time.
`timescale 1ns/100ps
`default_nettype none
module tb_serial_port_frame_engine
  import spfe_pkg::*;
;
  logic clock = 1'b0; // 10 MHz
  logic srst = 1'b1; // Held for 20 cycles
  spfe_req_s req; // Register request
  logic [7:0] rdata;
  logic baud_tick_16x = 1'b0;
  logic line; // Receive pin, driven by the node
  logic txd;
  logic go = 1'b0;
  logic [3:0] go_len = 4'd10;
  logic [10:0] go_bits = '0;
  logic [5:0] go_clks = 6'd32;
  logic [3:0] rx_len = 4'd10;
  logic p_busy;
  logic f_valid;
  logic [10:0] f_bits;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] rd_q[$]; // Expected read data
  logic [10:0] fr_q[$]; // Expected frames on txd
  logic rd_dly = 1'b0; // Read answer due this cycle
  logic [31:0] seed = 32'd55;
  logic [7:0] d0, d1, d2;
  logic [7:0] ctl;
  logic t9;
  logic m0_en = 1'b0; // Partner answers the shift clock
  logic [7:0] m0_byte = 8'h00;

  always #50 clock = ~clock;
  // Tick pulse on every second clock
  always @(posedge clock) baud_tick_16x <= ~baud_tick_16x;

  spfe_frame_engine dut_u (.clock(clock), .srst(srst), .req(req),
    .rdata(rdata), .baud_tick_16x(baud_tick_16x),
    .port_three_bit_zero(line), .txd(txd));

  spfe_remote_node node_u (.clock(clock), .srst(srst), .txd(txd),
    .line(line), .go(go), .go_len(go_len), .go_bits(go_bits),
    .go_clks(go_clks), .busy(p_busy), .m0_en(m0_en), .m0_byte(m0_byte),
    .rx_len(rx_len),
    .frame_valid(f_valid), .frame_bits(f_bits));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask

  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("counts: %0d mismatches in %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bus cycles: each holds its strobe for exactly one edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rd_q.push_back(exp);
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock);
  endtask

  // Wait until every expected frame has been seen
  task automatic wait_tx;
    int i;
    idle(1);
    for (i = 0; i < 3000 && fr_q.size() != 0; i++) @(posedge clock);
    if (fr_q.size() != 0) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time,
               fr_q.size(), 0);
      stop_test;
    end
    idle(40);
  endtask

  // Node sends one frame, then a margin for the hunt to resume
  task automatic send(input logic [3:0] n, input logic [10:0] b,
                      input logic [5:0] c);
    int i;
    idle(1);
    go <= 1'b1;
    go_len <= n;
    go_bits <= b;
    go_clks <= c;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 1000 && p_busy !== 1'b0; i++) @(posedge clock);
    if (p_busy !== 1'b0) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time,
               p_busy, 1'b0);
      stop_test;
    end
    idle(40);
  endtask

  // Watcher: read answers and captured frames against the oldest notes
  always @(posedge clock) begin
    rd_dly <= req.rd;
    if (rd_dly) begin
      check({3'b000, rdata}, {3'b000, rd_q.pop_front()});
    end
    if (f_valid === 1'b1) begin
      if (fr_q.size() == 0) begin
        check(f_bits, 11'h7FF);
      end else begin
        check(f_bits, fr_q.pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    req = '0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    // Reset values and unmapped place, back to back
    rd(SPFE_OFS_CTRL, SPFE_RST_CTRL);
    rd(SPFE_OFS_BUF, SPFE_RST_BUF);
    rd(SPFE_OFS_AUX, {6'h00, SPFE_RST_AUX});
    rd(2'h3, 8'h00);
    idle(2);
    $display("test reset done");
    // Mode 1 transmit; a second write mid-frame must be ignored
    rnd(d0);
    rx_len <= 4'd10;
    wr(SPFE_OFS_CTRL, 8'h40);
    fr_q.push_back({1'b0, 1'b1, d0, 1'b0});
    wr(SPFE_OFS_BUF, d0);
    idle(100);
    wr(SPFE_OFS_BUF, ~d0);
    wait_tx;
    check({10'h000, txd}, 11'h001);
    rd(SPFE_OFS_CTRL, 8'h42);
    wr(SPFE_OFS_CTRL, 8'h40);
    rd(SPFE_OFS_CTRL, 8'h40);
    idle(300);
    $display("test mode one transmit done");
    // Mode 3 transmit with both ninth-bit values, then mode 2 with ninth bit one
    rx_len <= 4'd11;
    for (int k = 0; k < 3; k++) begin
      rnd(d1);
      t9 = (k != 0);
      ctl = {(k == 2) ? SPFE_MODE_TWO : SPFE_MODE_THREE, 2'b00, t9, 3'b000};
      wr(SPFE_OFS_AUX, (k == 2) ? 8'h01 : 8'h00);
      wr(SPFE_OFS_CTRL, ctl);
      fr_q.push_back({1'b1, t9, d1, 1'b0});
      wr(SPFE_OFS_BUF, d1);
      wait_tx;
      rd(SPFE_OFS_CTRL, ctl | 8'h02);
    end
    wr(SPFE_OFS_AUX, 8'h00);
    $display("test nine-bit transmit done");
    // Mode 1 receive, then a frame lost while the flag is set
    rnd(d0);
    rnd(d1);
    rnd(d2);
    wr(SPFE_OFS_CTRL, 8'h50);
    send(4'd10, {1'b0, 1'b1, d0, 1'b0}, 6'd32);
    rd(SPFE_OFS_BUF, d0);
    rd(SPFE_OFS_CTRL, 8'h55);
    send(4'd10, {1'b0, 1'b1, d1, 1'b0}, 6'd32);
    rd(SPFE_OFS_BUF, d0);
    wr(SPFE_OFS_CTRL, 8'h50);
    send(4'd10, {1'b0, 1'b1, d2, 1'b0}, 6'd32);
    rd(SPFE_OFS_BUF, d2);
    rd(SPFE_OFS_CTRL, 8'h55);
    $display("test mode one receive done");
    // False start: a short low pulse must not start a frame
    wr(SPFE_OFS_CTRL, 8'h50);
    send(4'd1, 11'h000, 6'd4);
    idle(400);
    rd(SPFE_OFS_CTRL, 8'h50);
    $display("test false start done");
    // Mode 3 with multiprocessor filter on the ninth bit
    rnd(d0);
    rnd(d1);
    wr(SPFE_OFS_CTRL, 8'hF0);
    send(4'd11, {1'b1, 1'b0, d0, 1'b0}, 6'd32);
    rd(SPFE_OFS_CTRL, 8'hF0);
    send(4'd11, {1'b1, 1'b1, d1, 1'b0}, 6'd32);
    rd(SPFE_OFS_BUF, d1);
    rd(SPFE_OFS_CTRL, 8'hF5);
    idle(400);
    $display("test multiprocessor receive done");
    // Shift-mode receive in both clock options
    for (int k = 0; k < 2; k++) begin
      rnd(d0);
      wr(SPFE_OFS_CTRL, 8'h00);
      wr(SPFE_OFS_AUX, {6'h00, k[0], 1'b0});
      m0_byte <= d0;
      idle(2);
      m0_en <= 1'b1;
      idle(4);
      wr(SPFE_OFS_CTRL, 8'h10);
      idle(200);
      rd(SPFE_OFS_BUF, d0);
      rd(SPFE_OFS_CTRL, 8'h11);
      wr(SPFE_OFS_CTRL, 8'h00);
      idle(2);
      m0_en <= 1'b0;
    end
    wr(SPFE_OFS_AUX, 8'h00);
    idle(2);
    $display("test shift mode receive done");
    stop_test;
  end
endmodule
`default_nettype wire
